// ==== keypad_consts.svh ====
// Constants of the keyboard/display command port: opcodes, fields, timing.
// Assumes a single 100 MHz system clock and an 8-bit host bus.
`ifndef KEYPAD_CONSTS_SVH
`define KEYPAD_CONSTS_SVH

// ---------------------------------------------------------------
// Command byte fields
// ---------------------------------------------------------------
`define CMD_CLASS_HI 7
`define CMD_CLASS_LO 5
`define CMD_AI_BIT 4
`define CMD_ERR_BIT 4
`define CMD_KMODE_HI 2
`define CMD_DMODE_HI 4
`define CMD_DMODE_LO 3
`define CMD_ROW_HI 2
`define CMD_ADDR_HI 3
`define CMD_MASK_A_BIT 3
`define CMD_MASK_B_BIT 2
`define CMD_BLANK_A_BIT 1
`define CMD_BLANK_B_BIT 0
`define CMD_CD_HI 4
`define CMD_CD_MID 3
`define CMD_CD_LO 2
`define CMD_CF_BIT 1
`define CMD_CA_BIT 0

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define DMODE_RESET 2'h1
`define KMODE_RESET 3'h0
`define DIVISOR_RESET 5'h1F
`define DIVISOR_MIN 5'h02
`define BLANK_ZEROS 8'h00
`define BLANK_SPACE 8'h20
`define BLANK_ONES 8'hFF
`define CHARS_FOUR 5'h04
`define CHARS_EIGHT 5'h08
`define CHARS_SIXTEEN 5'h10
`define FIFO_FULL_COUNT 4'h8

// ---------------------------------------------------------------
// Status byte bit positions
// ---------------------------------------------------------------
`define ST_BUSY 7
`define ST_SE 6
`define ST_OVER 5
`define ST_UNDER 4
`define ST_FULL 3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define CLEAR_TIME_NS 160000

`endif

// ==== keypad_pkg.sv ====
// Types shared by the keyboard/display command port.
// Assumes the constants header is compiled alongside.
package keypad_pkg;

	// Command classes by the upper three bits
	typedef enum logic [2:0] {
		CMD_MODE_SET = 3'b000,
		CMD_PROG_CLOCK = 3'b001,
		CMD_READ_FIFO = 3'b010,
		CMD_READ_DISP = 3'b011,
		CMD_WRITE_DISP = 3'b100,
		CMD_INHIBIT = 3'b101,
		CMD_CLEAR = 3'b110,
		CMD_END_INT = 3'b111
	} cmd_class_e;

	// Source of host data reads
	typedef enum logic [0:0] {
		SRC_FIFO = 1'b0,
		SRC_DISPLAY = 1'b1
	} read_src_e;

endpackage

// ==== keypad_prescaler.sv ====
// Programmable prescaler producing the internal timing enable.
// Assumes divisor is held stable between program-clock commands.
`timescale 1ns/1ns
`include "keypad_consts.svh"

module keypad_prescaler (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Control
	input wire logic [4:0] prescale_divisor_in,
	input wire logic resync_in,
	// Enable out
	output logic tick_out
);

	logic [4:0] count;
	wire [4:0] eff_div;
	wire [4:0] terminal;
	wire at_end;

	// Divisors below the minimum would stall; treat them as the minimum
	assign eff_div = (prescale_divisor_in < `DIVISOR_MIN) ?
		`DIVISOR_MIN : prescale_divisor_in;
	assign terminal = eff_div - 5'h01;
	assign at_end = (count >= terminal);

	// Counter chain; resync restarts the phase
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || resync_in) begin
			count <= 5'h00;
			tick_out <= 1'b0;
		end else begin
			count <= at_end ? 5'h00 : count + 5'h01;
			tick_out <= at_end;
		end
	end

endmodule

// ==== keypad_display_command_port.sv ====
// Command decoder, FIFO/sensor memory and display memory of the
// keyboard/display controller, with its 8-bit host port.
// Assumes host strobes are synchronous to clk_sys_in and held for at
// least two cycles; scan logic outside supplies keys and sensor rows.
`timescale 1ns/1ns
`include "keypad_consts.svh"

module keypad_display_command_port #(
	parameter int CLEAR_CYCLES = `CLEAR_TIME_NS / `CLK_PERIOD_NS,
	parameter int FIFO_DEPTH = 8,
	parameter int DISP_ROWS = 16
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// Host bus
	input wire logic cs_n_in,
	input wire logic cmd_data_select_line_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic irq_out,
	// Scan side: key entries and sensor rows
	input wire logic key_entry_valid_in,
	input wire logic [7:0] key_entry_in,
	input wire logic multi_key_error_in,
	input wire logic sensor_row_valid_in,
	input wire logic [2:0] sensor_row_index_in,
	input wire logic [7:0] sensor_row_data_in,
	// Display refresh side
	input wire logic [3:0] refresh_addr_in,
	output logic [3:0] nibble_a_out,
	output logic [3:0] nibble_b_out,
	// Mode and timing outputs
	output logic [1:0] display_mode_field_out,
	output logic [2:0] keyboard_mode_field_out,
	output logic [4:0] display_chars_out,
	output logic error_mode_out,
	output logic scan_tick_out
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [1:0] display_mode_field;
	logic [2:0] keyboard_mode_field;
	logic [4:0] prescale_divisor;
	keypad_pkg::read_src_e read_src;
	logic fifo_auto_increment_flag;
	logic disp_auto_increment_flag;
	logic [3:0] disp_ptr;
	logic [2:0] sensor_ptr;
	logic nibble_write_mask_a;
	logic nibble_write_mask_b;
	logic nibble_suppress_flag_a;
	logic nibble_suppress_flag_b;
	logic [7:0] blank_code;
	logic [15:0] busy_count;
	logic busy;
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [2:0] fifo_wr_ptr;
	logic [2:0] fifo_rd_ptr;
	logic [3:0] fifo_count;
	logic overrun;
	logic underrun;
	logic sensor_irq;
	logic error_mode;
	logic se_error;
	logic [7:0] disp_mem [DISP_ROWS];
	logic wr_n_prev;
	logic rd_n_prev;

	// ---------------------------------------------------------------
	// Host strobe decode
	// ---------------------------------------------------------------
	// Rising edges of the strobes act; chip select must still be low
	wire wr_edge = wr_n_in && !wr_n_prev && !cs_n_in;
	wire rd_edge = rd_n_in && !rd_n_prev && !cs_n_in;
	wire cmd_wr = wr_edge && cmd_data_select_line_in;
	wire data_wr = wr_edge && !cmd_data_select_line_in;
	wire data_rd = rd_edge && !cmd_data_select_line_in;
	wire read_active = !cs_n_in && !rd_n_in;
	wire [2:0] cmd_code = data_in[`CMD_CLASS_HI:`CMD_CLASS_LO];

	// Command class decode
	wire is_mode = cmd_wr && cmd_code == keypad_pkg::CMD_MODE_SET;
	wire is_clock = cmd_wr && cmd_code == keypad_pkg::CMD_PROG_CLOCK;
	wire is_rfifo = cmd_wr && cmd_code == keypad_pkg::CMD_READ_FIFO;
	wire is_rdisp = cmd_wr && cmd_code == keypad_pkg::CMD_READ_DISP;
	wire is_wdisp = cmd_wr && cmd_code == keypad_pkg::CMD_WRITE_DISP;
	wire is_inhib = cmd_wr && cmd_code == keypad_pkg::CMD_INHIBIT;
	wire is_clear = cmd_wr && cmd_code == keypad_pkg::CMD_CLEAR;
	wire is_endint = cmd_wr && cmd_code == keypad_pkg::CMD_END_INT;

	// Mode decode
	wire decoded_scan = keyboard_mode_field[0];
	wire sensor_mode = keyboard_mode_field[2:1] == 2'b10;
	wire nkey_mode = keyboard_mode_field[2:1] == 2'b01;

	// Clear command fields
	wire clear_all = data_in[`CMD_CA_BIT];
	wire clr_disp = is_clear && (data_in[`CMD_CD_HI] || clear_all);
	wire clr_fifo = is_clear && (data_in[`CMD_CF_BIT] || clear_all);
	wire [7:0] clear_code = !data_in[`CMD_CD_HI] ? `BLANK_ZEROS :
		(data_in[`CMD_CD_MID] ? `BLANK_ONES : `BLANK_SPACE);

	// FIFO push and pop; a pending special error stops pushes
	wire fifo_full = fifo_count == `FIFO_FULL_COUNT;
	wire key_push = key_entry_valid_in && !sensor_mode && !se_error;
	wire push_ok = key_push && !fifo_full;
	wire fifo_pop_try = data_rd && read_src == keypad_pkg::SRC_FIFO &&
		!sensor_mode;
	wire pop_ok = fifo_pop_try && fifo_count != 4'h0;

	// Sensor change detection, blocked while an interrupt is pending
	wire sensor_change = sensor_mode && sensor_row_valid_in && !sensor_irq
		&& fifo_mem[sensor_row_index_in] != sensor_row_data_in;

	// Display write with nibble masks
	wire disp_wr_ok = data_wr && !busy;
	wire [7:0] disp_old = disp_mem[disp_ptr];
	wire [7:0] disp_new = {
		nibble_write_mask_a ? disp_old[7:4] : data_in[7:4],
		nibble_write_mask_b ? disp_old[3:0] : data_in[3:0]};
	wire disp_rd = data_rd && read_src == keypad_pkg::SRC_DISPLAY;

	// Status byte
	wire [7:0] status_byte = {busy, sensor_mode ? sensor_irq : se_error,
		overrun, underrun, fifo_full, fifo_count[2:0]};

	// Data read source
	wire [7:0] fifo_view = sensor_mode ? fifo_mem[sensor_ptr] :
		fifo_mem[fifo_rd_ptr];
	wire [7:0] data_view = (read_src == keypad_pkg::SRC_DISPLAY) ?
		disp_mem[disp_ptr] : fifo_view;
	wire [7:0] next_data_out = cmd_data_select_line_in ? status_byte :
		data_view;

	// Refresh view with per-nibble blanking
	wire [7:0] refresh_row = disp_mem[refresh_addr_in];
	wire [3:0] next_nibble_a = nibble_suppress_flag_a ? blank_code[7:4] :
		refresh_row[7:4];
	wire [3:0] next_nibble_b = nibble_suppress_flag_b ? blank_code[3:0] :
		refresh_row[3:0];

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Decoded scan shows only four characters
	assign display_chars_out = decoded_scan ? `CHARS_FOUR :
		(display_mode_field[0] ? `CHARS_SIXTEEN : `CHARS_EIGHT);
	assign display_mode_field_out = display_mode_field;
	assign keyboard_mode_field_out = keyboard_mode_field;
	assign error_mode_out = error_mode;
	assign data_oe_out = read_active;
	// Sensor modes signal changes; other modes signal FIFO contents or a pending special error
	assign irq_out = sensor_mode ? sensor_irq :
		(fifo_count != 4'h0 || se_error);

	// Strobe history and registered data outputs
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			wr_n_prev <= 1'b1;
			rd_n_prev <= 1'b1;
			data_out <= 8'h00;
			nibble_a_out <= 4'h0;
			nibble_b_out <= 4'h0;
		end else begin
			wr_n_prev <= wr_n_in;
			rd_n_prev <= rd_n_in;
			data_out <= next_data_out;
			nibble_a_out <= next_nibble_a;
			nibble_b_out <= next_nibble_b;
		end
	end

	// ---------------------------------------------------------------
	// Mode, clock, mask and error-mode registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			display_mode_field <= `DMODE_RESET;
			keyboard_mode_field <= `KMODE_RESET;
			prescale_divisor <= `DIVISOR_RESET;
			nibble_write_mask_a <= 1'b0;
			nibble_write_mask_b <= 1'b0;
			nibble_suppress_flag_a <= 1'b0;
			nibble_suppress_flag_b <= 1'b0;
			error_mode <= 1'b0;
		end else begin
			if (is_mode) begin
				display_mode_field <= data_in[`CMD_DMODE_HI:`CMD_DMODE_LO];
				keyboard_mode_field <= data_in[`CMD_KMODE_HI:0];
			end
			if (is_clock)
				prescale_divisor <= data_in[4:0];
			if (is_inhib) begin
				nibble_write_mask_a <= data_in[`CMD_MASK_A_BIT];
				nibble_write_mask_b <= data_in[`CMD_MASK_B_BIT];
				nibble_suppress_flag_a <= data_in[`CMD_BLANK_A_BIT];
				nibble_suppress_flag_b <= data_in[`CMD_BLANK_B_BIT];
			end
			if (is_endint && nkey_mode && data_in[`CMD_ERR_BIT])
				error_mode <= 1'b1;
			else if (is_mode)
				error_mode <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Pointers and read source
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			read_src <= keypad_pkg::SRC_FIFO;
			fifo_auto_increment_flag <= 1'b0;
			disp_auto_increment_flag <= 1'b0;
			disp_ptr <= 4'h0;
			sensor_ptr <= 3'h0;
		end else begin
			if (is_rfifo) begin
				read_src <= keypad_pkg::SRC_FIFO;
				fifo_auto_increment_flag <= data_in[`CMD_AI_BIT];
				sensor_ptr <= data_in[`CMD_ROW_HI:0];
			end else if (clr_fifo) begin
				sensor_ptr <= 3'h0;
			end else if (fifo_pop_try == 1'b0 && data_rd && sensor_mode &&
				read_src == keypad_pkg::SRC_FIFO && fifo_auto_increment_flag) begin
				sensor_ptr <= sensor_ptr + 3'h1;
			end
			if (is_rdisp)
				read_src <= keypad_pkg::SRC_DISPLAY;
			// Both display commands load the one shared pointer
			if (is_rdisp || is_wdisp) begin
				disp_auto_increment_flag <= data_in[`CMD_AI_BIT];
				disp_ptr <= data_in[`CMD_ADDR_HI:0];
			end else if (disp_auto_increment_flag &&
				(disp_wr_ok || disp_rd)) begin
				disp_ptr <= disp_ptr + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Clear sequencing
	// ---------------------------------------------------------------
	// The fill itself is instant; the busy window models the real
	// clear time so software sees the documented unavailability
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			busy_count <= 16'h0000;
			busy <= 1'b0;
			blank_code <= `BLANK_ZEROS;
		end else if (clr_disp) begin
			busy_count <= 16'(CLEAR_CYCLES - 1);
			busy <= 1'b1;
			blank_code <= clear_code;
		end else if (busy) begin
			busy_count <= busy_count - 16'h0001;
			busy <= busy_count != 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// FIFO / sensor memory
	// ---------------------------------------------------------------
	// A push in the cycle of a FIFO clear lands as the first entry unless the FIFO was full
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			fifo_wr_ptr <= 3'h0;
			fifo_rd_ptr <= 3'h0;
			fifo_count <= 4'h0;
			overrun <= 1'b0;
			underrun <= 1'b0;
			sensor_irq <= 1'b0;
			se_error <= 1'b0;
		end else if (clr_fifo) begin
			fifo_wr_ptr <= push_ok ? 3'h1 : 3'h0;
			fifo_rd_ptr <= 3'h0;
			fifo_count <= push_ok ? 4'h1 : 4'h0;
			overrun <= key_push && fifo_full;
			underrun <= 1'b0;
			sensor_irq <= sensor_change;
			se_error <= error_mode && multi_key_error_in;
		end else begin
			if (push_ok)
				fifo_wr_ptr <= fifo_wr_ptr + 3'h1;
			if (pop_ok)
				fifo_rd_ptr <= fifo_rd_ptr + 3'h1;
			fifo_count <= fifo_count + {3'h0, push_ok} - {3'h0, pop_ok};
			if (key_push && fifo_full)
				overrun <= 1'b1;
			if (fifo_pop_try && fifo_count == 4'h0)
				underrun <= 1'b1;
			// Set wins over the end-interrupt clear
			if (sensor_change)
				sensor_irq <= 1'b1;
			else if (is_endint && sensor_mode)
				sensor_irq <= 1'b0;
			if (error_mode && multi_key_error_in)
				se_error <= 1'b1;
		end
	end

	// One writer per entry: key push or sensor row update
	genvar gi;
	generate
		for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
			wire key_hit = push_ok && fifo_wr_ptr == 3'(gi) &&
				!clr_fifo;
			wire key_hit0 = push_ok && clr_fifo && gi == 0;
			wire sns_hit = sensor_change && sensor_row_index_in == 3'(gi);
			always_ff @(posedge clk_sys_in) begin
				if (reset_in)
					fifo_mem[gi] <= 8'h00;
				else if (key_hit || key_hit0)
					fifo_mem[gi] <= key_entry_in;
				else if (sns_hit)
					fifo_mem[gi] <= sensor_row_data_in;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Display memory
	// ---------------------------------------------------------------
	generate
		for (gi = 0; gi < DISP_ROWS; gi++) begin : g_disp
			wire row_hit = disp_wr_ok && disp_ptr == 4'(gi);
			always_ff @(posedge clk_sys_in) begin
				if (reset_in)
					disp_mem[gi] <= `BLANK_ZEROS;
				else if (clr_disp)
					disp_mem[gi] <= clear_code;
				else if (row_hit)
					disp_mem[gi] <= disp_new;
			end
		end
	endgenerate

	// Internal timing chain, resynchronised by clear-all
	keypad_prescaler u_prescaler (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.prescale_divisor_in(prescale_divisor),
		.resync_in(is_clear && clear_all),
		.tick_out(scan_tick_out)
	);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_clear_disp;
		clr_disp;
	endsequence
	sequence s_busy_run;
		busy [*8];
	endsequence

	property p_mode_latch;
		@(posedge clk_sys_in) disable iff (reset_in)
		is_mode |=> keyboard_mode_field == $past(data_in[2:0]);
	endproperty
	a_mode_latch: assert property (p_mode_latch)
		else $error("mode set not latched");

	property p_four_chars;
		@(posedge clk_sys_in) disable iff (reset_in)
		decoded_scan |-> display_chars_out == `CHARS_FOUR;
	endproperty
	a_four_chars: assert property (p_four_chars)
		else $error("decoded scan not limited to four");

	property p_divisor;
		@(posedge clk_sys_in) disable iff (reset_in)
		is_clock |=> prescale_divisor == $past(data_in[4:0]);
	endproperty
	a_divisor: assert property (p_divisor)
		else $error("divisor not loaded");

	property p_clear_busy;
		@(posedge clk_sys_in) disable iff (reset_in)
		s_clear_disp |=> s_busy_run;
	endproperty
	a_clear_busy: assert property (p_clear_busy)
		else $error("busy dropped too early");

	property p_status_busy;
		@(posedge clk_sys_in) disable iff (reset_in)
		read_active && cmd_data_select_line_in |=>
			data_out[`ST_BUSY] == $past(busy);
	endproperty
	a_status_busy: assert property (p_status_busy)
		else $error("status busy bit wrong");

	property p_irq_fifo;
		@(posedge clk_sys_in) disable iff (reset_in)
		!sensor_mode && fifo_count != 4'h0 |-> irq_out;
	endproperty
	a_irq_fifo: assert property (p_irq_fifo)
		else $error("irq low with FIFO entries");

	property p_underrun;
		@(posedge clk_sys_in) disable iff (reset_in)
		fifo_pop_try && fifo_count == 4'h0 && !clr_fifo |=>
			underrun && fifo_count == $past(fifo_count) +
			{3'h0, $past(push_ok)};
	endproperty
	a_underrun: assert property (p_underrun)
		else $error("underrun not flagged");

	property p_fifo_clear;
		@(posedge clk_sys_in) disable iff (reset_in)
		clr_fifo && !is_rfifo && !key_entry_valid_in |=>
			fifo_count == 4'h0 && sensor_ptr == 3'h0;
	endproperty
	a_fifo_clear: assert property (p_fifo_clear)
		else $error("FIFO clear incomplete");

	property p_end_int;
		@(posedge clk_sys_in) disable iff (reset_in)
		is_endint && sensor_mode && !sensor_change |=> !irq_out;
	endproperty
	a_end_int: assert property (p_end_int)
		else $error("end interrupt left irq high");

	property p_wr_inc;
		@(posedge clk_sys_in) disable iff (reset_in)
		disp_wr_ok && disp_auto_increment_flag |=>
			disp_ptr == $past(disp_ptr) + 4'h1;
	endproperty
	a_wr_inc: assert property (p_wr_inc)
		else $error("display pointer not advanced");

	property p_err_mode;
		@(posedge clk_sys_in) disable iff (reset_in)
		is_endint && nkey_mode && data_in[`CMD_ERR_BIT] |=> error_mode;
	endproperty
	a_err_mode: assert property (p_err_mode)
		else $error("special error mode not entered");

endmodule

// ==== keypad_scan_model.sv ====
// Scan-side stand-in: key entries and sensor rows as one-cycle pulses.
// Assumes the bench calls its tasks and shares the system clock.
`timescale 1ns/1ns

module keypad_scan_model (
	// Clock
	input wire logic clk_sys_in,
	// Scan outputs
	output logic key_valid_out,
	output logic [7:0] key_out,
	output logic row_valid_out,
	output logic [2:0] row_index_out,
	output logic [7:0] row_data_out
);
	// Idle levels; released data shows its inverse, never a stale value
	initial begin
		key_valid_out = 1'b0;
		key_out = 8'h00;
		row_valid_out = 1'b0;
		row_index_out = 3'h0;
		row_data_out = 8'h00;
	end
	// One key entry, pulse seen at one edge only
	task automatic push_key(input logic [7:0] d);
		@(posedge clk_sys_in) #1;
		key_out = d;
		key_valid_out = 1'b1;
		@(posedge clk_sys_in) #1;
		key_valid_out = 1'b0;
		key_out = ~d;
	endtask
	// One sensor row sample
	task automatic put_row(input logic [2:0] i, input logic [7:0] d);
		@(posedge clk_sys_in) #1;
		row_index_out = i;
		row_data_out = d;
		row_valid_out = 1'b1;
		@(posedge clk_sys_in) #1;
		row_valid_out = 1'b0;
		row_data_out = ~d;
	endtask
endmodule

// ==== keypad_display_command_port_tb.sv ====
// Self-checking bench for the keyboard/display command port.
// Assumes the design's header and files are compiled first.
`timescale 1ns/1ns

module keypad_display_command_port_tb;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic cs_n = 1'b1, sel = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
	logic [7:0] din = 8'h00, dout, q, key, sdat;
	logic oe, irq, kv, sv, emode, tick;
	logic mke = 1'b0;
	logic [2:0] sidx, kmode;
	logic [3:0] raddr = 4'h0, na, nb;
	logic [1:0] dmode;
	logic [4:0] chars;
	logic [7:0] cmd [3] = '{8'hD0, 8'hD8, 8'hC1};
	logic [7:0] fill [3] = '{8'h20, 8'hFF, 8'h00};
	int n_fail = 0;
	int samples_checked = 0;
	int i, k;

	// Clock; short clear window keeps the busy test quick
	always #5 clk_sys_in = ~clk_sys_in;

	keypad_display_command_port #(.CLEAR_CYCLES(20)) uut (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .cs_n_in(cs_n),
		.cmd_data_select_line_in(sel), .rd_n_in(rd_n), .wr_n_in(wr_n),
		.data_in(din), .data_out(dout), .data_oe_out(oe), .irq_out(irq),
		.key_entry_valid_in(kv), .key_entry_in(key),
		.multi_key_error_in(mke), .sensor_row_valid_in(sv),
		.sensor_row_index_in(sidx), .sensor_row_data_in(sdat),
		.refresh_addr_in(raddr), .nibble_a_out(na), .nibble_b_out(nb),
		.display_mode_field_out(dmode), .keyboard_mode_field_out(kmode),
		.display_chars_out(chars), .error_mode_out(emode),
		.scan_tick_out(tick));

	keypad_scan_model scan (
		.clk_sys_in(clk_sys_in), .key_valid_out(kv), .key_out(key),
		.row_valid_out(sv), .row_index_out(sidx), .row_data_out(sdat));

	// ----------------------------------------------------------------
	// Host bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write: strobe rises, next edge takes it, one more for effect
	task automatic wr(input logic a, input logic [7:0] d);
		@(posedge clk_sys_in) #1;
		cs_n = 1'b0;
		sel = a;
		wr_n = 1'b0;
		din = d;
		@(posedge clk_sys_in) #1;
		wr_n = 1'b1;
		@(posedge clk_sys_in) #1;
		cs_n = 1'b1;
		@(posedge clk_sys_in) #1;
	endtask
	// Read: data settles one cycle late, so rd is held two edges
	task automatic rd(input logic a, output logic [7:0] d);
		@(posedge clk_sys_in) #1;
		cs_n = 1'b0;
		sel = a;
		rd_n = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		d = dout;
		chk({7'h0, oe}, 8'h01);
		rd_n = 1'b1;
		@(posedge clk_sys_in) #1;
		cs_n = 1'b1;
	endtask
	// Spacing of scan ticks, bounded both waits
	task automatic tick_gap(output int n);
		for (n = 0; tick !== 1'b1 && n < 100; n++) @(posedge clk_sys_in) #1;
		chk({7'h0, tick}, 8'h01);
		if (tick !== 1'b1) report_and_stop();
		for (n = 1; n < 100; n++) begin
			@(posedge clk_sys_in) #1;
			if (tick === 1'b1) break;
		end
		chk({7'h0, tick}, 8'h01);
		if (tick !== 1'b1) report_and_stop();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		reset_in = 1'b0;
		chk({3'h0, kmode, dmode}, 8'h01);
		rd(1'b1, q);
		chk(q, 8'h00);
		// Every mode-set code; the character count follows the fields
		for (i = 0; i < 32; i++) begin
			wr(1'b1, 8'(i));
			chk({3'h0, kmode, dmode}, {3'h0, i[2:0], i[4:3]});
			chk({3'h0, chars}, i[0] ? 8'h04 : (i[3] ? 8'h10 : 8'h08));
		end
		// Divisor at both ends of its range
		wr(1'b1, 8'h22);
		tick_gap(k);
		chk(8'(k), 8'h02);
		wr(1'b1, 8'h3F);
		tick_gap(k);
		chk(8'(k), 8'h1F);
		// FIFO overfilled, drained in order, then read once too often
		wr(1'b1, 8'h00);
		for (i = 0; i < 9; i++) scan.push_key(8'(8'h30 + i));
		rd(1'b1, q);
		chk(q, 8'h28);
		chk({7'h0, irq}, 8'h01);
		wr(1'b1, 8'h57);
		for (i = 0; i < 8; i++) begin
			rd(1'b0, q);
			chk(q, 8'(8'h30 + i));
		end
		rd(1'b0, q);
		rd(1'b1, q);
		chk(q & 8'h1F, 8'h10);
		chk({7'h0, irq}, 8'h00);
		wr(1'b1, 8'hC2);
		rd(1'b1, q);
		chk(q, 8'h00);
		// Display writes and reads through the shared pointer
		wr(1'b1, 8'h90);
		for (i = 0; i < 3; i++) wr(1'b0, 8'(8'hA0 + i));
		wr(1'b1, 8'h70);
		for (i = 0; i < 3; i++) begin
			rd(1'b0, q);
			chk(q, 8'(8'hA0 + i));
		end
		wr(1'b1, 8'h82);
		rd(1'b0, q);
		chk(q, 8'hA2);
		// Nibble A masked: only the low nibble may change
		wr(1'b1, 8'hA8);
		wr(1'b1, 8'h81);
		wr(1'b0, 8'h5F);
		wr(1'b1, 8'h61);
		rd(1'b0, q);
		chk(q, 8'hAF);
		wr(1'b1, 8'hA3);
		chk({na, nb}, 8'h00);
		// Each clear code; a write inside the busy window is dropped
		for (i = 0; i < 3; i++) begin
			wr(1'b1, cmd[i]);
			rd(1'b1, q);
			chk(q & 8'h80, 8'h80);
			wr(1'b0, 8'h55);
			for (k = 0; q[7] !== 1'b0 && k < 20; k++) rd(1'b1, q);
			chk(q & 8'h80, 8'h00);
			if (q[7] !== 1'b0) report_and_stop();
			chk({na, nb}, fill[i]);
			wr(1'b1, 8'h61);
			rd(1'b0, q);
			chk(q, fill[i]);
		end
		// Sensor change raises irq and locks the rows until end-interrupt
		wr(1'b1, 8'h04);
		scan.put_row(3'h4, 8'h11);
		chk({7'h0, irq}, 8'h01);
		wr(1'b1, 8'hE0);
		chk({7'h0, irq}, 8'h00);
		scan.put_row(3'h3, 8'h5A);
		scan.put_row(3'h4, 8'h99);
		wr(1'b1, 8'h53);
		rd(1'b0, q);
		chk(q, 8'h5A);
		rd(1'b0, q);
		chk(q, 8'h11);
		// Special error mode entered from rollover mode
		wr(1'b1, 8'h02);
		wr(1'b1, 8'hF0);
		chk({7'h0, emode}, 8'h01);
		// A multiple-key error blocks pushes and raises irq until cleared
		@(posedge clk_sys_in) #1;
		mke = 1'b1;
		@(posedge clk_sys_in) #1;
		mke = 1'b0;
		scan.push_key(8'h77);
		rd(1'b1, q);
		chk(q, 8'h40);
		chk({7'h0, irq}, 8'h01);
		wr(1'b1, 8'hC2);
		rd(1'b1, q);
		chk(q, 8'h00);
		chk({7'h0, irq}, 8'h00);
		report_and_stop();
	end
endmodule
